// *** ewd_if.sv ***
// Purpose: Two-wire link between master and memory slave
// Assumes: Open-drain lines with pull-ups
// Notes:   A line is low while any enabled driver drives low
`timescale 1ns/100ps
`default_nettype none
interface ewd_if;
  logic mSclOut;
  logic mSclOe;
  logic mSdaOut;
  logic mSdaOe;
  logic sSdaOut;
  logic sSdaOe;
  logic scl;
  logic sda;

  assign scl = ~(mSclOe & ~mSclOut);
  assign sda = ~((mSdaOe & ~mSdaOut) | (sSdaOe & ~sSdaOut));

  modport slave  (input scl, input sda, output sSdaOut, output sSdaOe);
  modport master (input scl, input sda, output mSclOut, output mSclOe, output mSdaOut, output mSdaOe);
endinterface : ewd_if
`default_nettype wire

// *** ewd_master.sv ***
// Purpose: Two-wire bus master driven by software through four registers
// Assumes: Software builds each transfer from start, byte and stop commands
// Notes:   No clock stretching; the slave never holds the clock low
`timescale 1ns/100ps
`default_nettype none
module ewd_master (
  input  wire logic                        clk,
  input  wire logic                        rstn,
  ewd_if.master                            bus,
  input  wire logic [ewd_pkg::REG_AW-1:0]  addr,
  input  wire logic [31:0]                 wrData,
  input  wire logic                        wrEn,
  input  wire logic                        rdEn,
  output logic      [31:0]                 rdData
);
  logic                          sclS;
  logic                          sdaS;
  logic [7:0]                    div_reg;
  logic [7:0]                    divCnt_reg;
  logic [ewd_pkg::BYTE_W-1:0]    tx_reg;
  logic [ewd_pkg::BYTE_W-1:0]    rx_reg;
  logic [ewd_pkg::CMD_W-1:0]     cmd_reg;
  logic                          busy_reg;
  logic                          ackSeen_reg;
  logic [3:0]                    slot_reg;
  logic [1:0]                    phase_reg;
  logic                          sclOe_reg;
  logic                          sdaOe_reg;
  logic                          tick;
  logic                          isByte;
  logic                          isRead;
  logic                          launch;
  logic                          bitDrive;
  logic [3:0]                    lastSlot;

  ewd_sync #(.W(2)) uSync (
    .clk  (clk),
    .rstn (rstn),
    .d    ({bus.scl, bus.sda}),
    .q    ({sclS, sdaS})
  );

  assign isRead   = (cmd_reg == ewd_pkg::CMD_READ_ACK) || (cmd_reg == ewd_pkg::CMD_READ_NACK);
  assign isByte   = isRead || (cmd_reg == ewd_pkg::CMD_WRITE);
  assign lastSlot = isByte ? ewd_pkg::LAST_BYTE_SLOT : 4'h0;
  assign tick     = busy_reg && (divCnt_reg == div_reg);
  assign launch   = wrEn && !busy_reg && (addr == ewd_pkg::REG_CMD) &&
                    (wrData[ewd_pkg::CMD_W-1:0] >= ewd_pkg::CMD_START) &&
                    (wrData[ewd_pkg::CMD_W-1:0] <= ewd_pkg::CMD_READ_NACK);

  // Nine slots per byte; the ninth carries the acknowledge
  always_comb begin
    if (slot_reg == ewd_pkg::LAST_BYTE_SLOT) begin
      bitDrive = (cmd_reg == ewd_pkg::CMD_READ_ACK);
    end else if (isRead) begin
      bitDrive = 1'b0;
    end else begin
      bitDrive = ~tx_reg[3'(ewd_pkg::BYTE_W - 1) - slot_reg[2:0]];
    end
  end

  // Configuration and data registers; refused while a command runs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_reg <= ewd_pkg::DIV_RESET;
      tx_reg  <= '0;
    end else if (wrEn && !busy_reg) begin
      if (addr == ewd_pkg::REG_DIV) begin
        div_reg <= wrData[7:0];
      end
      if (addr == ewd_pkg::REG_TX) begin
        tx_reg <= wrData[ewd_pkg::BYTE_W-1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      divCnt_reg <= '0;
    end else if (!busy_reg || tick) begin
      divCnt_reg <= '0;
    end else begin
      divCnt_reg <= divCnt_reg + 1'b1;
    end
  end

  // Quarter-bit sequencer: for byte commands drive data, raise clock, sample, lower clock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd_reg     <= '0;
      busy_reg    <= 1'b0;
      slot_reg    <= '0;
      phase_reg   <= '0;
      sclOe_reg   <= 1'b0;
      sdaOe_reg   <= 1'b0;
      rx_reg      <= '0;
      ackSeen_reg <= 1'b0;
    end else if (launch) begin
      cmd_reg   <= wrData[ewd_pkg::CMD_W-1:0];
      busy_reg  <= 1'b1;
      slot_reg  <= '0;
      phase_reg <= '0;
    end else if (tick) begin
      phase_reg <= phase_reg + 1'b1;
      if (phase_reg == 2'h3) begin
        slot_reg <= slot_reg + 1'b1;
        busy_reg <= (slot_reg != lastSlot);
      end
      case (cmd_reg)
        ewd_pkg::CMD_START: begin
          case (phase_reg)
            2'h0:    sdaOe_reg <= 1'b0;
            2'h1:    sclOe_reg <= 1'b0;
            2'h2:    sdaOe_reg <= 1'b1;
            default: sclOe_reg <= 1'b1;
          endcase
        end
        ewd_pkg::CMD_STOP: begin
          case (phase_reg)
            2'h0:    sdaOe_reg <= 1'b1;
            2'h1:    sclOe_reg <= 1'b0;
            2'h2:    sdaOe_reg <= 1'b0;
            default: sclOe_reg <= 1'b0;
          endcase
        end
        default: begin
          case (phase_reg)
            2'h0:    sdaOe_reg <= bitDrive;
            2'h1:    sclOe_reg <= 1'b0;
            2'h2: begin
              if (!isRead && slot_reg == ewd_pkg::LAST_BYTE_SLOT) begin
                ackSeen_reg <= ~sdaS;
              end else if (isRead && slot_reg != ewd_pkg::LAST_BYTE_SLOT) begin
                rx_reg <= {rx_reg[ewd_pkg::BYTE_W-2:0], sdaS};
              end
            end
            default: sclOe_reg <= 1'b1;
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdData <= '0;
    end else if (rdEn) begin
      case (addr)
        ewd_pkg::REG_CMD:  rdData <= 32'(cmd_reg);
        ewd_pkg::REG_TX:   rdData <= 32'(tx_reg);
        ewd_pkg::REG_DIV:  rdData <= 32'(div_reg);
        ewd_pkg::REG_STAT: rdData <= (32'(rx_reg) << ewd_pkg::STAT_RX_LSB) |
                                     (32'(ackSeen_reg) << ewd_pkg::STAT_ACK_BIT) |
                                     (32'(busy_reg) << ewd_pkg::STAT_BUSY_BIT);
        default:           rdData <= '0;
      endcase
    end else begin
      rdData <= '0;
    end
  end

  assign bus.mSclOut = 1'b0;
  assign bus.mSclOe  = sclOe_reg;
  assign bus.mSdaOut = 1'b0;
  assign bus.mSdaOe  = sdaOe_reg;
endmodule : ewd_master
`default_nettype wire

// *** ewd_monitor.sv ***
// Purpose: Concurrent checks on the two-wire link and the slave's reset outputs
// Assumes: Sees resolved lines and the slave's data-line enable
// Notes:   Idle time is measured from real line edges, so bounds carry sync slack
`timescale 1ns/100ps
`default_nettype none
module ewd_monitor #(
  parameter int WdogCycles = 3000,
  parameter int HoldCycles = 600
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic sSdaOe,
  input  wire logic resetOut,
  input  wire logic resetOutN,
  input  wire logic supplyBelowLevel
);
  logic sdaPrev_reg;
  int   idleCnt_reg;
  int   hiCnt_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) sdaPrev_reg <= 1'b1;
    else sdaPrev_reg <= sda;
  end

  // Cleared by any data-line edge and held while reset is active
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) idleCnt_reg <= 0;
    else if (resetOut || sda != sdaPrev_reg) idleCnt_reg <= 0;
    else idleCnt_reg <= idleCnt_reg + 1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) hiCnt_reg <= 0;
    else if (resetOut) hiCnt_reg <= hiCnt_reg + 1;
    else hiCnt_reg <= 0;
  end

  sequence s_stop;
    scl && $rose(sda);
  endsequence
  sequence s_fire;
    $rose(resetOut);
  endsequence

  a_reset_pair: assert property (resetOutN == !resetOut)
    else $error("reset outputs not complementary");
  a_ack_in_reset: assert property (resetOut ##1 resetOut |-> !sSdaOe)
    else $error("slave drives data line during reset");
  a_supply_lock: assert property (supplyBelowLevel ##1 supplyBelowLevel |-> ##[0:4] resetOut)
    else $error("low supply did not raise reset");
  a_hold_min: assert property ($fell(resetOut) |-> hiCnt_reg >= HoldCycles)
    else $error("reset released before hold time");
  a_wdog_bound: assert property (idleCnt_reg <= WdogCycles + 8)
    else $error("watchdog did not fire on idle data line");
  a_wdog_early: assert property (s_fire |-> idleCnt_reg >= WdogCycles - 8 || supplyBelowLevel)
    else $error("reset raised before watchdog interval");
  a_sda_stable: assert property (scl && $past(scl) |-> $stable(sSdaOe))
    else $error("slave changed data line with clock high");
  a_drive_late: assert property ($rose(sSdaOe) |-> !scl && !$past(scl, 3))
    else $error("slave drive not inside clock low phase");
  a_stop_quiet: assert property (s_stop |=> !sSdaOe [*8])
    else $error("slave drove data line after stop");
endmodule : ewd_monitor
`default_nettype wire

// *** ewd_pkg.sv ***
// Purpose: Shared constants for the serial memory slave and its bus master
// Assumes: 200 MHz system clock on both ends
// Notes:   Times are kept in their own unit; cycle counts derive from them
`default_nettype none
package ewd_pkg;
  localparam int CLK_MHZ         = 200;
  localparam int KHZ_PER_MHZ     = 1000;
  // Watchdog interval 1.6 s, kept in ms
  localparam int WDOG_MS         = 1600;
  localparam int WDOG_CYCLES     = WDOG_MS * CLK_MHZ * KHZ_PER_MHZ;
  localparam int RST_HOLD_MS     = 200;
  localparam int RST_HOLD_CYCLES = RST_HOLD_MS * CLK_MHZ * KHZ_PER_MHZ;
  localparam int PROG_MS         = 10;
  localparam int PROG_CYCLES     = PROG_MS * CLK_MHZ * KHZ_PER_MHZ;
  localparam int CNT_W           = 32;

  localparam int MEM_AW          = 11;
  localparam int MEM_DEPTH       = 2048;
  localparam int PAGE_AW         = 4;
  localparam int PAGE_LEN        = 16;
  localparam int BYTE_W          = 8;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] DEV_TYPE  = 4'hA;

  // Master register map (byte addresses) and fields
  localparam int REG_AW            = 4;
  localparam logic [3:0] REG_CMD   = 4'h0;
  localparam logic [3:0] REG_TX    = 4'h4;
  localparam logic [3:0] REG_STAT  = 4'h8;
  localparam logic [3:0] REG_DIV   = 4'hC;
  localparam int STAT_BUSY_BIT     = 0;
  localparam int STAT_ACK_BIT      = 1;
  localparam int STAT_RX_LSB       = 8;
  localparam logic [7:0] DIV_RESET = 8'h7C;
  localparam int CMD_W             = 3;
  localparam logic [2:0] CMD_START     = 3'h1;
  localparam logic [2:0] CMD_STOP      = 3'h2;
  localparam logic [2:0] CMD_WRITE     = 3'h3;
  localparam logic [2:0] CMD_READ_ACK  = 3'h4;
  localparam logic [2:0] CMD_READ_NACK = 3'h5;
  localparam logic [3:0] LAST_BYTE_SLOT = 4'h8;
endpackage : ewd_pkg
`default_nettype wire

// *** ewd_slave.sv ***
// Purpose: Serial memory slave with supply lockout and data-line watchdog
// Assumes: Link lines sampled by clk through two flops
// Notes:   Tags below mark the logic that carries each rule
// Operation
// - Watchdog timeout after 1.6 s raises reset
// - Any data-line edge clears watchdog
// - Watchdog held at zero during reset
// - Write-protect high makes array read only
// - Low supply inhibits all array writes
// - Reset active: ignore access, never acknowledge
// - Start is data fall with clock high
// - Master ends every operation with stop
// - Data changes with clock high mean start/stop
// - Match 1010, next three bits upper address
// - Last address bit: 1 read, 0 write
// - Receiver acknowledges low on ninth clock
// - Acknowledge every write byte unless forbidden
// - Read: release, sample master acknowledge, continue
// - Byte write sequence; stop starts programming
// - Ignore everything while programming runs
// - Page of sixteen, low bits increment
// - Extra page bytes wrap and overwrite
// - Address acknowledge withheld while busy
// - Protected: no acknowledge on first data
// - Counter is last address plus one
// - Random read via dummy write, restart
// - Reset outputs held about 200 ms
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module ewd_slave #(
  parameter int unsigned WdogCycles = ewd_pkg::WDOG_CYCLES,
  parameter int unsigned HoldCycles = ewd_pkg::RST_HOLD_CYCLES,
  parameter int unsigned ProgCycles = ewd_pkg::PROG_CYCLES
) (
  input  wire logic clk,
  input  wire logic rstn,
  ewd_if.slave      bus,
  input  wire logic writeProtect,
  input  wire logic supplyBelowLevel,
  output logic      resetOut,
  output logic      resetOutN
);
  typedef enum logic [2:0] {S_IDLE, S_DEV, S_WORD, S_DATA, S_READ} ewd_slv_state_t;

  logic                          sclS;
  logic                          sdaS;
  logic                          lowS;
  logic                          wpS;
  logic                          sclPrev_reg;
  logic                          sdaPrev_reg;
  logic                          startSeen;
  logic                          stopSeen;
  logic                          sclRise;
  logic                          sclFall;
  logic                          sdaEdge;
  logic [ewd_pkg::CNT_W-1:0]     wdCnt_reg;
  logic [ewd_pkg::CNT_W-1:0]     holdCnt_reg;
  logic [ewd_pkg::CNT_W-1:0]     progCnt_reg;
  logic                          wdTimeout;
  logic                          progDone;
  logic                          rstActive_reg;
  logic                          busy_reg;
  ewd_slv_state_t                state_reg;
  logic [3:0]                    bitCnt_reg;
  logic                          ackPhase_reg;
  logic                          masterAck_reg;
  logic                          sdaOe_reg;
  logic [ewd_pkg::BYTE_W-1:0]    shift_reg;
  logic [ewd_pkg::BYTE_W-1:0]    tx_reg;
  logic [ewd_pkg::MEM_AW-1:0]    addrCnt_reg;
  logic [ewd_pkg::PAGE_LEN-1:0]  pendMask_reg;
  logic [ewd_pkg::BYTE_W-1:0]    pageBuf [ewd_pkg::PAGE_LEN];
  logic [ewd_pkg::BYTE_W-1:0]    mem     [ewd_pkg::MEM_DEPTH];
  logic [ewd_pkg::BYTE_W-1:0]    memRd;
  logic                          ackOk;

  ewd_sync #(.W(4)) uSync (
    .clk  (clk),
    .rstn (rstn),
    .d    ({bus.scl, bus.sda, supplyBelowLevel, writeProtect}),
    .q    ({sclS, sdaS, lowS, wpS})
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
    end else begin
      sclPrev_reg <= sclS;
      sdaPrev_reg <= sdaS;
    end
  end

  assign startSeen = sclS & sclPrev_reg & sdaPrev_reg & ~sdaS;
  assign stopSeen  = sclS & sclPrev_reg & ~sdaPrev_reg & sdaS;
  assign sclRise   = sclS & ~sclPrev_reg;
  assign sclFall   = ~sclS & sclPrev_reg;
  assign sdaEdge   = sdaS ^ sdaPrev_reg;

  // Watchdog on data-line activity
  assign wdTimeout = (wdCnt_reg == ewd_pkg::CNT_W'(WdogCycles - 1));
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wdCnt_reg <= '0;
    end else if (rstActive_reg || sdaEdge || wdTimeout) begin
      wdCnt_reg <= '0;
    end else begin
      wdCnt_reg <= wdCnt_reg + 1'b1;
    end
  end

  // Reset hold: low supply keeps it loaded, so the timeout runs from recovery
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      holdCnt_reg   <= '0;
      rstActive_reg <= 1'b1;
    end else begin
      if (lowS || wdTimeout) begin
        holdCnt_reg <= ewd_pkg::CNT_W'(HoldCycles);
      end else if (holdCnt_reg != '0) begin
        holdCnt_reg <= holdCnt_reg - 1'b1;
      end
      rstActive_reg <= lowS || wdTimeout || (holdCnt_reg > ewd_pkg::CNT_W'(1));
    end
  end

  assign resetOut  = rstActive_reg;
  assign resetOutN = ~rstActive_reg;

  // Internal programming cycle
  assign progDone = busy_reg && (progCnt_reg == ewd_pkg::CNT_W'(ProgCycles - 1));
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_reg    <= 1'b0;
      progCnt_reg <= '0;
    end else if (progDone) begin
      busy_reg    <= 1'b0;
      progCnt_reg <= '0;
    end else if (busy_reg) begin
      progCnt_reg <= progCnt_reg + 1'b1;
    end else if (stopSeen && !rstActive_reg && state_reg == S_DATA && pendMask_reg != '0 && !wpS) begin
      busy_reg <= 1'b1;
    end
  end

  // Whole page lands in one cycle; a supply dip at that moment drops it
  always_ff @(posedge clk) begin
    if (progDone && !lowS) begin
      for (int i = 0; i < ewd_pkg::PAGE_LEN; i++) begin
        if (pendMask_reg[i]) begin
          mem[{addrCnt_reg[ewd_pkg::MEM_AW-1:ewd_pkg::PAGE_AW], ewd_pkg::PAGE_AW'(i)}] <= pageBuf[i];
        end
      end
    end
  end

  assign memRd = mem[addrCnt_reg];

  always_comb begin
    case (state_reg)
      S_DEV:   ackOk = (shift_reg[7:4] == ewd_pkg::DEV_TYPE);
      S_WORD:  ackOk = 1'b1;
      S_DATA:  ackOk = !wpS && !lowS;
      default: ackOk = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (state_reg == S_DATA && sclFall && bitCnt_reg == ewd_pkg::BYTE_BITS && !ackPhase_reg && ackOk) begin
      pageBuf[addrCnt_reg[ewd_pkg::PAGE_AW-1:0]] <= shift_reg;
    end
  end

  // Byte protocol engine
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg     <= S_IDLE;
      bitCnt_reg    <= '0;
      ackPhase_reg  <= 1'b0;
      masterAck_reg <= 1'b0;
      sdaOe_reg     <= 1'b0;
      shift_reg     <= '0;
      tx_reg        <= '0;
      addrCnt_reg   <= '0;
      pendMask_reg  <= '0;
    end else if (progDone) begin
      pendMask_reg <= '0;
    end else if (rstActive_reg) begin
      state_reg    <= S_IDLE;
      ackPhase_reg <= 1'b0;
      sdaOe_reg    <= 1'b0;
    end else if (startSeen) begin
      state_reg    <= busy_reg ? S_IDLE : S_DEV;
      bitCnt_reg   <= '0;
      ackPhase_reg <= 1'b0;
      sdaOe_reg    <= 1'b0;
    end else if (stopSeen) begin
      state_reg    <= S_IDLE;
      ackPhase_reg <= 1'b0;
      sdaOe_reg    <= 1'b0;
    end else begin
      case (state_reg)
        S_DEV, S_WORD, S_DATA: begin
          if (sclRise && !ackPhase_reg && bitCnt_reg != ewd_pkg::BYTE_BITS) begin
            shift_reg  <= {shift_reg[ewd_pkg::BYTE_W-2:0], sdaS};
            bitCnt_reg <= bitCnt_reg + 1'b1;
          end else if (sclFall && !ackPhase_reg && bitCnt_reg == ewd_pkg::BYTE_BITS) begin
            ackPhase_reg <= 1'b1;
            sdaOe_reg    <= ackOk;
            if (ackOk && state_reg == S_DEV) begin
              addrCnt_reg[ewd_pkg::MEM_AW-1:ewd_pkg::BYTE_W] <= shift_reg[3:1];
            end
            if (state_reg == S_WORD) begin
              addrCnt_reg[ewd_pkg::BYTE_W-1:0] <= shift_reg;
              pendMask_reg                     <= '0;
            end
            if (ackOk && state_reg == S_DATA) begin
              pendMask_reg[addrCnt_reg[ewd_pkg::PAGE_AW-1:0]] <= 1'b1;
              addrCnt_reg[ewd_pkg::PAGE_AW-1:0] <= addrCnt_reg[ewd_pkg::PAGE_AW-1:0] + 1'b1;
            end
          end else if (sclFall && ackPhase_reg) begin
            ackPhase_reg <= 1'b0;
            bitCnt_reg   <= '0;
            sdaOe_reg    <= 1'b0;
            if (!sdaOe_reg) begin
              state_reg <= S_IDLE;  // Unacknowledged byte: wait for next start
            end else if (state_reg == S_DEV && shift_reg[0]) begin
              state_reg   <= S_READ;
              tx_reg      <= memRd;
              sdaOe_reg   <= ~memRd[ewd_pkg::BYTE_W-1];
              addrCnt_reg <= addrCnt_reg + 1'b1;
            end else if (state_reg == S_DEV) begin
              state_reg <= S_WORD;
            end else begin
              state_reg <= S_DATA;
            end
          end
        end
        S_READ: begin
          if (sclRise && ackPhase_reg) begin
            masterAck_reg <= ~sdaS;
          end else if (sclRise) begin
            bitCnt_reg <= bitCnt_reg + 1'b1;
          end else if (sclFall && ackPhase_reg) begin
            ackPhase_reg <= 1'b0;
            bitCnt_reg   <= '0;
            if (masterAck_reg) begin
              tx_reg      <= memRd;
              sdaOe_reg   <= ~memRd[ewd_pkg::BYTE_W-1];
              addrCnt_reg <= addrCnt_reg + 1'b1;
            end else begin
              state_reg <= S_IDLE;
            end
          end else if (sclFall && bitCnt_reg == ewd_pkg::BYTE_BITS) begin
            sdaOe_reg    <= 1'b0;
            ackPhase_reg <= 1'b1;
          end else if (sclFall) begin
            tx_reg    <= {tx_reg[ewd_pkg::BYTE_W-2:0], 1'b0};
            sdaOe_reg <= ~tx_reg[ewd_pkg::BYTE_W-2];
          end
        end
        default: begin
          sdaOe_reg <= 1'b0;
        end
      endcase
    end
  end

  assign bus.sSdaOut = 1'b0;
  assign bus.sSdaOe  = sdaOe_reg;
endmodule : ewd_slave
`default_nettype wire

// *** ewd_sync.sv ***
// Purpose: Two-stage synchroniser for asynchronous inputs
// Assumes: Each bit is an independent level
// Notes:   Only the second stage leaves this module
`timescale 1ns/100ps
`default_nettype none
module ewd_sync #(
  parameter int              W        = 1,
  parameter logic [W-1:0]    ResetVal = '1
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic [W-1:0]  d,
  output logic      [W-1:0]  q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= ResetVal;
      q        <= ResetVal;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : ewd_sync
`default_nettype wire

// *** testbench.sv ***
// Purpose: Runs master and memory slave together through register commands
// Assumes: Short watchdog, hold and program counts; quarter bit of five cycles
// Notes:   Ack and received byte come back through the master's status word
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int WdC = 3000;
  localparam int HoC = 600;
  localparam int PrC = 400;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wrData = 32'h0;
  logic        wrEn = 1'b0;
  logic        rdEn = 1'b0;
  logic [31:0] rdData;
  logic        writeProtect = 1'b0;
  logic        supplyBelowLevel = 1'b0;
  logic        resetOut;
  logic        resetOutN;
  logic [31:0] s;
  int          err_total = 0;
  int          checks = 0;
  int          cyc = 0;
  int          t0;
  int          i;

  ewd_if bus ();
  ewd_slave #(.WdogCycles(WdC), .HoldCycles(HoC), .ProgCycles(PrC)) ewd_slave_i (.clk(clk), .rstn(rstn),
    .bus(bus), .writeProtect(writeProtect), .supplyBelowLevel(supplyBelowLevel), .resetOut(resetOut),
    .resetOutN(resetOutN));
  ewd_master ewd_master_i (.clk(clk), .rstn(rstn), .bus(bus), .addr(addr), .wrData(wrData), .wrEn(wrEn),
    .rdEn(rdEn), .rdData(rdData));
  ewd_monitor #(.WdogCycles(WdC), .HoldCycles(HoC)) ewd_monitor_i (.clk(clk), .rstn(rstn), .scl(bus.scl),
    .sda(bus.sda), .sSdaOe(bus.sSdaOe), .resetOut(resetOut), .resetOutN(resetOutN),
    .supplyBelowLevel(supplyBelowLevel));

  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  task test_done();
    if (err_total == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done

  task check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : check

  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1;
    s = rdData;
  endtask : rd

  // Issues one command and polls busy with a bound
  task op(input logic [2:0] c, input logic [7:0] b);
    int n;
    if (c == ewd_pkg::CMD_WRITE) wr(ewd_pkg::REG_TX, {24'h0, b});
    wr(ewd_pkg::REG_CMD, {29'h0, c});
    for (n = 0; n < 400; n++) begin
      rd(ewd_pkg::REG_STAT);
      if (s[ewd_pkg::STAT_BUSY_BIT] === 1'b0) break;
    end
    if (n == 400) begin
      err_total++;
      test_done();
    end
  endtask : op

  task wb(input logic [7:0] b, input logic e);
    op(ewd_pkg::CMD_WRITE, b);
    check({31'h0, s[ewd_pkg::STAT_ACK_BIT]}, {31'h0, e});
  endtask : wb

  task sa(input logic [7:0] b, input logic e);
    op(ewd_pkg::CMD_START, 8'h00);
    wb(b, e);
  endtask : sa

  task rb(input logic [2:0] c, input logic [7:0] e);
    op(c, 8'h00);
    check({24'h0, s[15:8]}, {24'h0, e});
  endtask : rb

  task rrd(input logic [7:0] lo, input logic [7:0] e);
    sa(8'hA2, 1'b1);
    wb(lo, 1'b1);
    sa(8'hA3, 1'b1);
    rb(ewd_pkg::CMD_READ_NACK, e);
    op(ewd_pkg::CMD_STOP, 8'h00);
  endtask : rrd

  task waitRo(input logic v, input int lim);
    int n;
    for (n = 0; n < lim && resetOut !== v; n++) begin
      @(posedge clk);
      #1;
    end
    if (resetOut !== v) begin
      err_total++;
      test_done();
    end
  endtask : waitRo

  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1;
    t0 = cyc;
    wr(ewd_pkg::REG_DIV, 32'h4);
    rd(ewd_pkg::REG_DIV);
    check(s, 32'h4);
    sa(8'hA0, 1'b0);
    op(ewd_pkg::CMD_STOP, 8'h00);
    check({31'h0, resetOut}, 32'h1);
    waitRo(1'b0, 2 * HoC);
    check({31'h0, (cyc - t0 >= HoC) && (cyc - t0 <= HoC + 8)}, 32'h1);
    sa(8'hA2, 1'b1);
    wb(8'h1E, 1'b1);
    for (i = 0; i < 18; i++) wb(8'h40 + i[7:0], 1'b1);
    op(ewd_pkg::CMD_STOP, 8'h00);
    sa(8'hA2, 1'b0);
    i = 0;
    do begin
      op(ewd_pkg::CMD_START, 8'h00);
      op(ewd_pkg::CMD_WRITE, 8'hA2);
      i++;
    end while (s[ewd_pkg::STAT_ACK_BIT] !== 1'b1 && i < 10);
    check({31'h0, s[ewd_pkg::STAT_ACK_BIT]}, 32'h1);
    wb(8'h10, 1'b1);
    sa(8'hA3, 1'b1);
    for (i = 0; i < 14; i++) rb(ewd_pkg::CMD_READ_ACK, 8'h42 + i[7:0]);
    rb(ewd_pkg::CMD_READ_NACK, 8'h50);
    op(ewd_pkg::CMD_STOP, 8'h00);
    sa(8'hA3, 1'b1);
    rb(ewd_pkg::CMD_READ_NACK, 8'h51);
    op(ewd_pkg::CMD_STOP, 8'h00);
    sa(8'hB2, 1'b0);
    op(ewd_pkg::CMD_STOP, 8'h00);
    @(posedge clk);
    writeProtect <= 1'b1;
    sa(8'hA2, 1'b1);
    wb(8'h10, 1'b1);
    wb(8'h99, 1'b0);
    op(ewd_pkg::CMD_STOP, 8'h00);
    @(posedge clk);
    writeProtect <= 1'b0;
    rrd(8'h10, 8'h42);
    @(posedge clk);
    supplyBelowLevel <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    check({31'h0, resetOut}, 32'h1);
    sa(8'hA2, 1'b0);
    wb(8'h10, 1'b0);
    wb(8'h77, 1'b0);
    op(ewd_pkg::CMD_STOP, 8'h00);
    @(posedge clk);
    supplyBelowLevel <= 1'b0;
    waitRo(1'b0, 2 * HoC);
    rrd(8'h10, 8'h42);
    t0 = cyc;
    waitRo(1'b1, WdC + 100);
    check({31'h0, (cyc - t0 >= WdC - 30) && (cyc - t0 <= WdC + 10)}, 32'h1);
    waitRo(1'b0, HoC + 100);
    t0 = cyc;
    waitRo(1'b1, WdC + 100);
    check({31'h0, (cyc - t0 >= WdC - 4) && (cyc - t0 <= WdC + 8)}, 32'h1);
    test_done();
  end
endmodule : testbench
`default_nettype wire
